//--- hw/prog_timer.sv
/*
  Operation timer standing in for the RC-oscillator timebase.
  Assumes start is a single-cycle pulse and is not repeated while busy.
*/
`timescale 1ns/100ps
`default_nettype none
module prog_timer #(
  parameter int unsigned PROG_CYCLES = self_program_pkg::PROG_CYC
) (
  // Clock and reset
  input  wire logic mclk,
  input  wire logic rst_n,
  // Sequencer side
  prog_timer_if.timer tif
);
  logic [23:0] cnt_q;   // Remaining cycles
  logic        done_q;  // Finish pulse

  // ==========================================================================
  // Countdown; done fires in the cycle after the last count
  always_ff @(posedge mclk or negedge rst_n) begin
    if (!rst_n) begin
      cnt_q  <= 24'h000000;
      done_q <= 1'b0;
    end else begin
      done_q <= (cnt_q == 24'h000001);
      if (tif.start) begin
        cnt_q <= 24'(PROG_CYCLES);
      end else if (cnt_q != 24'h000000) begin
        cnt_q <= cnt_q - 24'h000001;
      end
    end
  end

  assign tif.busy = (cnt_q != 24'h000000) || done_q;
  assign tif.done = done_q;
endmodule // prog_timer
`default_nettype wire

//--- hw/prog_timer_if.sv
/*
  Interface between the control sequencer and its operation timer.
  Assumes both ends share mclk.
*/
`timescale 1ns/100ps
`default_nettype none
interface prog_timer_if;
  logic start;   // One-cycle start pulse
  logic busy;    // Operation in progress
  logic done;    // One-cycle finish pulse
  modport ctrl  (output start, input busy, input done);
  modport timer (input start, output busy, output done);
endinterface
`default_nettype wire

//--- hw/self_program_control.sv
/*
  Self-programming flash control: control register, command arming window,
  operation timing, page buffer and concurrent-section read blocking.
  Assumes a core that issues register writes and store/load strobes
  synchronous to mclk, and a flash array that accepts page commands.
*/
`timescale 1ns/100ps
`default_nettype none
module self_program_control (
  // Clock and reset
  input  wire logic        mclk,
  input  wire logic        rst_n,
  // Register access from the core
  input  wire logic        io_wr,
  input  wire logic        io_rd,
  input  wire logic        io_data_space,
  input  wire logic [7:0]  io_addr,
  input  wire logic [7:0]  io_wdata,
  output logic      [7:0]  io_rdata,
  // Store / load program memory from the core
  input  wire logic        store_req,
  input  wire logic        load_req,
  input  wire logic [15:0] z_ptr,
  input  wire logic [15:0] store_data,
  output logic             load_byte_hi,
  // Status and fuses
  input  wire logic        global_irq_en,
  input  wire logic        eeprom_write_busy,
  input  wire logic        boot_size_hi,
  input  wire logic        boot_size_lo,
  // To the core
  output logic             program_ready_irq,
  output logic             core_halt,
  output logic      [11:0] boot_start,
  // Read blocking
  input  wire logic [11:0] fetch_addr,
  output logic             fetch_blocked,
  // Flash array side
  output logic             flash_erase,
  output logic             flash_write,
  output logic             flash_lock_write,
  output logic      [6:0]  flash_page,
  output logic      [15:0] flash_wdata,
  output logic      [4:0]  flash_word,
  output logic      [7:0]  lock_data
);
  // ==========================================================================
  // States of the sequencer
  typedef enum logic [2:0] {
    ST_IDLE  = 3'b001,   // Nothing armed
    ST_ARMED = 3'b010,   // Waiting for store within the window
    ST_PROG  = 3'b100    // Timed operation running
  } state_t;

  state_t      state_q, state_d;
  logic [4:0]  cmd_q;              // Armed low five bits
  logic [1:0]  win_q;              // Cycles left in the arm window
  logic        irq_en_q;           // Ready interrupt enable
  logic        busy_q;             // Concurrent section busy
  logic        prog_hi_q;          // Running op targets blocking area
  logic [6:0]  page_q;             // Latched page
  logic [15:0] buf_q [32];         // Temporary page buffer
  logic [7:0]  lock_q;             // Lock data latch
  logic        erase_q, write_q, lockw_q;

  prog_timer_if tif ();

  prog_timer u_timer (
    .mclk  (mclk),
    .rst_n (rst_n),
    .tif   (tif)
  );

  // ==========================================================================
  // Decoding
  // Address hit; data space adds the usual 0x20 offset
  wire       reg_hit   = io_data_space ? (io_addr == self_program_pkg::CTRL_DATA_ADDR)
                                       : (io_addr == {2'b00, self_program_pkg::CTRL_IO_ADDR});
  wire       reg_wr    = io_wr && reg_hit;
  wire [4:0] wr_cmd    = io_wdata[4:0];
  // Only the listed patterns count; writing a command while one runs is refused
  wire       cmd_legal = (wr_cmd == self_program_pkg::CMD_REENABLE) ||
                         (wr_cmd == self_program_pkg::CMD_LOCK_WR)  ||
                         (wr_cmd == self_program_pkg::CMD_PAGE_WR)  ||
                         (wr_cmd == self_program_pkg::CMD_PAGE_ER)  ||
                         (wr_cmd == self_program_pkg::CMD_FILL);
  wire       arm       = reg_wr && cmd_legal && (state_q == ST_IDLE)
                         && !eeprom_write_busy;
  wire       fire      = (state_q == ST_ARMED) && store_req;
  // Z15:Z13 and Z0 never reach the array
  wire [6:0] z_page    = z_ptr[12:6];
  wire [4:0] z_word    = z_ptr[5:1];

  // Does a word address fall in the concurrently readable area
  function automatic logic in_conc(input logic [11:0] a);
    in_conc = (a <= self_program_pkg::CONC_LAST);
  endfunction

  wire       page_conc = in_conc({z_page, 5'b00000});
  wire       is_erase  = fire && (cmd_q == self_program_pkg::CMD_PAGE_ER);
  wire       is_write  = fire && (cmd_q == self_program_pkg::CMD_PAGE_WR);
  wire       is_lock   = fire && (cmd_q == self_program_pkg::CMD_LOCK_WR);
  wire       is_fill   = fire && (cmd_q == self_program_pkg::CMD_FILL);
  wire       is_reen   = fire && (cmd_q == self_program_pkg::CMD_REENABLE);
  wire       prog_op   = is_erase || is_write;
  wire       store_en  = (state_q != ST_IDLE);
  wire [7:0] ctrl_view = {irq_en_q, busy_q, 1'b0,
                          (store_en ? cmd_q : 5'b00000)};

  // ==========================================================================
  // Sequencer next state
  always_comb begin
    state_d = state_q;
    case (state_q)
      ST_IDLE:  if (arm) state_d = ST_ARMED;
      ST_ARMED: begin
        if (prog_op || is_lock) state_d = ST_PROG;
        else if (fire || win_q == 2'b00) state_d = ST_IDLE;
      end
      ST_PROG:  if (tif.done) state_d = ST_IDLE;
      default:  state_d = ST_IDLE;
    endcase
  end

  assign tif.start = (state_q == ST_ARMED) && (prog_op || is_lock);

  // ==========================================================================
  // Control state
  always_ff @(posedge mclk or negedge rst_n) begin
    if (!rst_n) begin
      state_q   <= ST_IDLE;
      cmd_q     <= self_program_pkg::CTRL_RESET[4:0];
      win_q     <= 2'b00;
      irq_en_q  <= 1'b0;
      busy_q    <= 1'b0;
      prog_hi_q <= 1'b0;
      page_q    <= 7'h00;
      lock_q    <= 8'hff;
      erase_q   <= 1'b0;
      write_q   <= 1'b0;
      lockw_q   <= 1'b0;
    end else begin
      state_q <= state_d;
      erase_q <= is_erase;
      write_q <= is_write;
      lockw_q <= is_lock;
      if (reg_wr) irq_en_q <= io_wdata[self_program_pkg::BIT_IRQ_EN];
      // Window counts the four cycles after the write cycle
      if (arm) begin
        cmd_q <= wr_cmd;
        win_q <= 2'(self_program_pkg::ARM_CYCLES - 1);
      end else if (state_q == ST_ARMED && win_q != 2'b00) begin
        win_q <= win_q - 2'b01;
      end
      if (prog_op) page_q <= z_page;
      // Halt flag follows each start, so a lock write never inherits an old erase's area
      if (tif.start) prog_hi_q <= prog_op && !page_conc;
      if (is_lock) lock_q <= store_data[7:0];
      // Busy: set beats clear; core writes to bit 6 are dropped
      if (prog_op && page_conc) busy_q <= 1'b1;
      else if (is_reen || is_fill) busy_q <= 1'b0;
    end
  end

  // ==========================================================================
  // Temporary page buffer, one word per plain store
  always_ff @(posedge mclk) begin
    if (is_fill) buf_q[z_word] <= store_data;
  end

  // ==========================================================================
  // Outputs
  assign io_rdata          = (io_rd && reg_hit) ? ctrl_view : 8'h00;
  assign load_byte_hi      = load_req && z_ptr[0];
  assign program_ready_irq = irq_en_q && global_irq_en && !store_en;
  // Halt across the whole erase/write of the blocking area
  assign core_halt         = (state_q == ST_PROG) && prog_hi_q && !lockw_q;
  // Concurrent area unreadable while busy; blocking area always readable
  assign fetch_blocked     = busy_q && in_conc(fetch_addr);
  assign boot_start        = ({boot_size_hi, boot_size_lo} == 2'b11) ? self_program_pkg::BOOT_START_3 :
                             ({boot_size_hi, boot_size_lo} == 2'b10) ? self_program_pkg::BOOT_START_2 :
                             ({boot_size_hi, boot_size_lo} == 2'b01) ? self_program_pkg::BOOT_START_1 :
                                                                       self_program_pkg::BOOT_START_0;
  assign flash_erase       = erase_q;
  assign flash_write       = write_q;
  assign flash_lock_write  = lockw_q;
  assign flash_page        = page_q;
  assign flash_word        = z_word;
  assign flash_wdata       = buf_q[z_word];          // Buffer word picked by the pointer's word bits
  assign lock_data         = lock_q;

  // ==========================================================================
  // Checks
  property p_arm_window;
    @(posedge mclk) disable iff (!rst_n)
    (arm && !store_req) ##1 (!store_req)[*4] |=> (state_q == ST_IDLE);
  endproperty
  a_arm_window: assert property (p_arm_window) else $error("Arm window overran");

  property p_bad_cmd;
    @(posedge mclk) disable iff (!rst_n)
    (reg_wr && !cmd_legal && state_q == ST_IDLE) |=> (state_q == ST_IDLE);
  endproperty
  a_bad_cmd: assert property (p_bad_cmd) else $error("Illegal command armed");

  property p_ee_block;
    @(posedge mclk) disable iff (!rst_n)
    (state_q == ST_IDLE && eeprom_write_busy) |=> (state_q == ST_IDLE);
  endproperty
  a_ee_block: assert property (p_ee_block) else $error("Command taken during EEPROM write");

  property p_busy_set;
    @(posedge mclk) disable iff (!rst_n)
    (prog_op && page_conc) |=> busy_q;
  endproperty
  a_busy_set: assert property (p_busy_set) else $error("Busy not set");

  property p_busy_clr;
    @(posedge mclk) disable iff (!rst_n)
    (is_reen || is_fill) |=> !busy_q;
  endproperty
  a_busy_clr: assert property (p_busy_clr) else $error("Busy not cleared");

  property p_irq;
    @(posedge mclk) disable iff (!rst_n)
    program_ready_irq |-> (irq_en_q && global_irq_en && state_q == ST_IDLE);
  endproperty
  a_irq: assert property (p_irq) else $error("Ready interrupt wrong");

  property p_block;
    @(posedge mclk) disable iff (!rst_n)
    (fetch_addr > self_program_pkg::CONC_LAST) |-> !fetch_blocked;
  endproperty
  a_block: assert property (p_block) else $error("Blocking area was blocked");

  property p_halt;
    @(posedge mclk) disable iff (!rst_n)
    (prog_op && !page_conc) |=> core_halt[*4];
  endproperty
  a_halt: assert property (p_halt) else $error("Core not halted");

  // Lock writes leave the whole flash readable, so the core keeps running
  property p_lock_nohalt;
    @(posedge mclk) disable iff (!rst_n)
    is_lock |=> (!core_halt)[*4];
  endproperty
  a_lock_nohalt: assert property (p_lock_nohalt) else $error("Core halted for lock write");

  property p_prog_len;
    @(posedge mclk) disable iff (!rst_n)
    tif.start |=> (state_q == ST_PROG)[*8];
  endproperty
  a_prog_len: assert property (p_prog_len) else $error("Operation ended early");
endmodule // self_program_control
`default_nettype wire

//--- hw/self_program_pkg.sv
/*
  Constants, register layout and timing for the self-programming flash control.
  Assumes a 20 MHz system clock and a 12-bit word-addressed program flash.
*/
package self_program_pkg;
  // ==========================================================================
  // Register access
  localparam logic [5:0]  CTRL_IO_ADDR   = 6'h37;   // I/O space offset
  localparam logic [7:0]  CTRL_DATA_ADDR = 8'h57;   // Data space address
  localparam logic [7:0]  CTRL_RESET     = 8'h00;   // Reset value
  // ==========================================================================
  // Field positions
  localparam int BIT_IRQ_EN   = 7;
  localparam int BIT_BUSY     = 6;
  localparam int BIT_REENABLE = 4;
  localparam int BIT_LOCK_WR  = 3;
  localparam int BIT_PAGE_WR  = 2;
  localparam int BIT_PAGE_ER  = 1;
  localparam int BIT_STORE_EN = 0;
  // ==========================================================================
  // Accepted command codes in the lower five bits
  localparam logic [4:0] CMD_REENABLE = 5'h11;
  localparam logic [4:0] CMD_LOCK_WR  = 5'h09;
  localparam logic [4:0] CMD_PAGE_WR  = 5'h05;
  localparam logic [4:0] CMD_PAGE_ER  = 5'h03;
  localparam logic [4:0] CMD_FILL     = 5'h01;
  // ==========================================================================
  // Geometry
  localparam int          PC_W        = 12;
  localparam int          PAGE_WORDS  = 32;
  localparam int          WORD_SEL_W  = 5;
  localparam int          PAGE_SEL_W  = 7;
  localparam logic [11:0] CONC_LAST   = 12'hbff;    // Last concurrently readable word
  localparam logic [11:0] BOOT_START_3 = 12'hf80;
  localparam logic [11:0] BOOT_START_2 = 12'hf00;
  localparam logic [11:0] BOOT_START_1 = 12'he00;
  localparam logic [11:0] BOOT_START_0 = 12'hc00;
  // ==========================================================================
  // Timing
  localparam int CLK_HZ       = 20_000_000;
  localparam int ARM_CYCLES   = 4;                  // Store window after arming
  localparam int PROG_MIN_US  = 3700;
  localparam int PROG_MAX_US  = 4500;
  // Both scale by whole MHz, exact at 20 MHz; target sits midway between them
  localparam int PROG_MIN_CYC = (PROG_MIN_US * (CLK_HZ / 1_000_000));
  localparam int PROG_MAX_CYC = (PROG_MAX_US * (CLK_HZ / 1_000_000));
  localparam int PROG_CYC     = (PROG_MIN_CYC + PROG_MAX_CYC) / 2;
endpackage

//--- testbench/core_model.sv
/* Core-side partner: register cycles and store/load strobes.
   Assumes mclk from the bench; every task starts and ends after a falling edge. */
`timescale 1ns/100ps
`default_nettype none
module core_model (
  // Clock and status
  input  wire logic        mclk,
  input  wire logic        eeprom_write_busy,
  // Register access
  output logic             io_wr,
  output logic             io_rd,
  output logic             io_data_space,
  output logic      [7:0]  io_addr,
  output logic      [7:0]  io_wdata,
  input  wire logic [7:0]  io_rdata,
  // Program memory strobes
  output logic             store_req,
  output logic             load_req,
  output logic      [15:0] z_ptr,
  output logic      [15:0] store_data
);
  // ======
  // Idle levels from time zero
  initial begin
    {io_wr, io_rd, io_data_space, store_req, load_req} = '0;
    {io_addr, io_wdata} = 16'h0000;
    {z_ptr, store_data} = 32'h0000_0000;
  end
  // ======
  // Register write; data scrambled after release so nothing stale stands
  task automatic wr(input logic [7:0] a, input logic ds, input logic [7:0] d);
    {io_wr, io_rd, io_addr, io_data_space, io_wdata} = {1'b1, 1'b0, a, ds, d};
    @(posedge mclk);
    @(negedge mclk);
    {io_wr, io_wdata} = {1'b0, ~d};
  endtask
  // Register read, data taken at the sampling edge
  // Strobe stays up so back-to-back reads touch each pin once; the next write or strobe lowers it
  task automatic rd(input logic [7:0] a, input logic ds, output logic [7:0] q);
    {io_rd, io_addr, io_data_space} = {1'b1, a, ds};
    @(posedge mclk);
    q = io_rdata;
    @(negedge mclk);
  endtask
  // Store strobe with the byte select forced low
  task automatic st(input logic [15:0] z, input logic [15:0] d);
    {store_req, io_rd, z_ptr, store_data} = {1'b1, 1'b0, z[15:1], 1'b0, d};
    @(posedge mclk);
    @(negedge mclk);
    {store_req, z_ptr, store_data} = {1'b0, ~z, ~d};
  endtask
  // Load strobe
  task automatic ld(input logic [15:0] z);
    {load_req, io_rd, z_ptr} = {1'b1, 1'b0, z};
    @(posedge mclk);
    @(negedge mclk);
    {load_req, z_ptr} = {1'b0, ~z};
  endtask
  // Pointer held for buffer read-back
  task automatic setz(input logic [15:0] z);
    z_ptr = z;
  endtask
  // Command only once idle and no EEPROM write; interrupts assumed masked
  task automatic cmd(input logic [7:0] v);
    logic [7:0] q;
    q = 8'h01;
    for (int i = 0; i < 100000 && (q[0] || eeprom_write_busy); i++) rd(8'h37, 1'b0, q);
    wr(8'h37, 1'b0, v);
  endtask
endmodule  // core_model
`default_nettype wire

//--- testbench/tb.sv
/* Self-checking bench: core partner, queued expectations, one full erase.
   Assumes the design keeps its default programming time (about 82k cycles). */
`timescale 1ns/100ps
`default_nettype none
module tb;
  typedef struct packed { logic [3:0] sel; logic [15:0] v; } note_t;
  localparam logic [3:0] S_RD = 4'h0, S_IRQ = 4'h1, S_HALT = 4'h2, S_BOOT = 4'h3, S_FB = 4'h4, S_ER = 4'h5,
                         S_WR = 4'h6, S_PG = 4'h7, S_WD = 4'h8, S_BHI = 4'h9, S_LK = 4'ha, S_LD = 4'hb,
                         S_FW = 4'hc;
  // ======
  // Design signals, named as the ports
  logic        mclk, rst_n, io_wr, io_rd, io_data_space, store_req, load_req, load_byte_hi;
  logic        global_irq_en, eeprom_write_busy, boot_size_hi, boot_size_lo;
  logic        program_ready_irq, core_halt, fetch_blocked, flash_erase, flash_write;
  logic [7:0]  io_addr, io_wdata, io_rdata, q, lock_data;
  logic        flash_lock_write;
  logic [4:0]  flash_word;
  logic [15:0] z_ptr, store_data, flash_wdata;
  logic [11:0] boot_start, fetch_addr;
  logic [6:0]  flash_page, pg;
  // Bench state
  note_t       nq[$];
  note_t       n;
  int          fail_count, checked, cyc, cnt;
  logic [31:0] rs;
  logic [4:0]  w[4];
  logic [15:0] d[4];
  logic [7:0]  bad[5] = '{8'hc7, 8'hd3, 8'hcb, 8'hdf, 8'hc2};  // Illegal low patterns, bit 6 set
  logic [11:0] bst[4] = '{12'hc00, 12'he00, 12'hf00, 12'hf80};
  // ======
  // Instances
  self_program_control DUT (.mclk, .rst_n, .io_wr, .io_rd, .io_data_space, .io_addr, .io_wdata, .io_rdata,
    .store_req, .load_req, .z_ptr, .store_data, .load_byte_hi, .global_irq_en, .eeprom_write_busy,
    .boot_size_hi, .boot_size_lo, .program_ready_irq, .core_halt, .boot_start, .fetch_addr, .fetch_blocked,
    .flash_erase, .flash_write, .flash_lock_write, .flash_page, .flash_wdata, .flash_word, .lock_data);
  core_model core (.mclk, .eeprom_write_busy, .io_wr, .io_rd, .io_data_space, .io_addr, .io_wdata, .io_rdata,
    .store_req, .load_req, .z_ptr, .store_data);
  // ======
  // 20 MHz clock
  initial begin
    mclk = 1'b0;
    forever #25 mclk = ~mclk;
  end
  // ======
  // Helpers
  function automatic logic [31:0] xs(input logic [31:0] s);
    s = s ^ (s << 13);
    s = s ^ (s >> 17);
    return s ^ (s << 5);
  endfunction
  function automatic logic [15:0] obs(input logic [3:0] s);
    case (s)
      S_RD:    return 16'(io_rdata);
      S_IRQ:   return 16'(program_ready_irq);
      S_HALT:  return 16'(core_halt);
      S_BOOT:  return 16'(boot_start);
      S_FB:    return 16'(fetch_blocked);
      S_ER:    return 16'(flash_erase);
      S_WR:    return 16'(flash_write);
      S_PG:    return 16'(flash_page);
      S_WD:    return flash_wdata;
      S_LK:    return 16'(flash_lock_write);
      S_LD:    return 16'(lock_data);
      S_FW:    return 16'(flash_word);
      default: return 16'(load_byte_hi);
    endcase
  endfunction
  task automatic check(input logic [15:0] seen, input logic [15:0] want);
    checked++;
    if (seen !== want) begin
      fail_count++;
      $display("[ERR] t=%0t seen=%h exp=%h", $time, seen, want);
    end
  endtask
  // Note for the next rising edge
  task automatic ex(input logic [3:0] s, input logic [15:0] v);
    nq.push_back({s, v});
  endtask
  task automatic tick(input int k);
    repeat (k) begin
      @(posedge mclk);
      @(negedge mclk);
    end
  endtask
  task automatic results();
    $display("checked %0d fail_count %0d", checked, fail_count);
    if (fail_count == 0 && checked > 0) $display("DONE - PASS");
    else $display("DONE - FAIL");
    $finish;
  endtask
  // ======
  // Watcher: every note queued for this edge against settled outputs
  always @(posedge mclk) begin
    while (nq.size() > 0) begin
      n = nq.pop_front();
      check(obs(n.sel), n.v);
    end
  end
  // Hang guard; one erase takes about 82k cycles
  always @(posedge mclk) begin
    cyc++;
    if (cyc == 95000) begin
      fail_count++;
      results();
    end
  end
  // ======
  // Main sequence
  initial begin
    {rst_n, global_irq_en, eeprom_write_busy, boot_size_hi, boot_size_lo} = '0;
    {fail_count, checked, cyc} = '0;
    fetch_addr = 12'h000;
    rs = 32'd71;
    repeat (2) @(posedge mclk);
    @(negedge mclk);
    rst_n = 1'b1;
    // Reset value on both maps; unmapped write lands nowhere
    ex(S_RD, 16'h0000);
    core.rd(8'h57, 1'b1, q);
    core.wr(8'h36, 1'b0, 8'h80);
    ex(S_RD, 16'h0000);
    core.rd(8'h37, 1'b0, q);
    // Enable via data space, read via I/O; interrupt follows global flag
    core.wr(8'h57, 1'b1, 8'h80);
    global_irq_en = 1'b1;
    ex(S_RD, 16'h0080);
    ex(S_IRQ, 16'h0001);
    core.rd(8'h37, 1'b0, q);
    global_irq_en = 1'b0;
    ex(S_IRQ, 16'h0000);
    tick(1);
    global_irq_en = 1'b1;
    // Arm window opens then lapses with no store
    core.wr(8'h37, 1'b0, 8'h81);
    ex(S_IRQ, 16'h0000);
    ex(S_RD, 16'h0081);
    core.rd(8'h37, 1'b0, q);
    tick(4);
    ex(S_RD, 16'h0080);
    core.rd(8'h37, 1'b0, q);
    // Illegal patterns and busy-flag writes change nothing
    foreach (bad[i]) begin
      core.wr(8'h37, 1'b0, bad[i]);
      ex(S_RD, 16'h0080);
      core.rd(8'h37, 1'b0, q);
    end
    // Boot start per fuse pair
    for (int i = 0; i < 4; i++) begin
      {boot_size_hi, boot_size_lo} = 2'(i);
      ex(S_BOOT, 16'(bst[i]));
      tick(1);
    end
    // Byte select on loads; an edge passes between the two strobes
    ex(S_BHI, 16'h0001);
    core.ld(16'he001);
    tick(1);
    ex(S_BHI, 16'h0000);
    core.ld(16'h0002);
    // Fill four buffer words, then read them back from another page
    rs = xs(rs);
    for (int i = 0; i < 4; i++) begin
      w[i] = 5'(rs[4:0] + 5'(i * 8));
      d[i] = rs[31:16] ^ 16'(i * 16'h1111);
      core.wr(8'h57, 1'b1, 8'h81);
      core.st({rs[i+:3], 7'h10, w[i], 1'b0}, d[i]);
    end
    ex(S_RD, 16'h0080);
    core.rd(8'h37, 1'b0, q);
    for (int i = 0; i < 4; i++) begin
      core.setz({~rs[i+:3], 7'h2a, w[i], 1'b1});
      ex(S_WD, d[i]);
      ex(S_FW, 16'(w[i]));
      tick(1);
    end
    // EEPROM write refuses the command; store then does nothing
    eeprom_write_busy = 1'b1;
    core.wr(8'h37, 1'b0, 8'h83);
    ex(S_RD, 16'h0080);
    core.rd(8'h37, 1'b0, q);
    core.st(16'h0040, 16'h0000);
    ex(S_ER, 16'h0000);
    tick(1);
    eeprom_write_busy = 1'b0;
    // Store five cycles after arming is too late
    core.wr(8'h37, 1'b0, 8'h83);
    tick(4);
    core.st(16'h0040, 16'h0000);
    ex(S_ER, 16'h0000);
    tick(1);
    // Erase of a concurrent page, store on the last armed cycle
    pg = 7'(rs[15:0] % 16'd96);
    core.cmd(8'h83);
    tick(3);
    fetch_addr = 12'hbff;
    core.st({3'b101, pg, 6'h00}, 16'h0000);
    ex(S_ER, 16'h0001);
    ex(S_PG, 16'(pg));
    ex(S_HALT, 16'h0000);
    ex(S_FB, 16'h0001);
    ex(S_IRQ, 16'h0000);
    ex(S_RD, 16'h00c3);
    core.rd(8'h37, 1'b0, q);
    fetch_addr = 12'hc00;
    ex(S_FB, 16'h0000);
    core.wr(8'h37, 1'b0, 8'h80);
    ex(S_RD, 16'h00c3);
    core.rd(8'h37, 1'b0, q);
    // Wait out the operation and judge its length
    cnt = 3;
    q = 8'h01;
    while (q[0] && cnt < 100000) begin
      core.rd(8'h37, 1'b0, q);
      cnt++;
    end
    check(16'(cnt >= self_program_pkg::PROG_MIN_CYC && cnt <= self_program_pkg::PROG_MAX_CYC), 16'h0001);
    fetch_addr = 12'h000;
    ex(S_RD, 16'h00c0);
    ex(S_FB, 16'h0001);
    ex(S_IRQ, 16'h0001);
    core.rd(8'h37, 1'b0, q);
    // Re-enable clears the busy flag
    core.cmd(8'h91);
    core.st(16'h0000, 16'h0000);
    ex(S_RD, 16'h0080);
    ex(S_FB, 16'h0000);
    core.rd(8'h37, 1'b0, q);
    // Page write in the blocking area halts the core, no busy flag
    core.cmd(8'h85);
    core.st({3'b011, 7'h64, 6'h00}, 16'h0000);
    ex(S_WR, 16'h0001);
    ex(S_PG, 16'h0064);
    ex(S_HALT, 16'h0001);
    ex(S_FB, 16'h0000);
    ex(S_RD, 16'h0085);
    core.rd(8'h37, 1'b0, q);
    // Reset in mid-operation drops the halt and every control bit
    rst_n = 1'b0;
    ex(S_HALT, 16'h0000);
    ex(S_LD, 16'h00ff);
    ex(S_RD, 16'h0000);
    core.rd(8'h37, 1'b0, q);
    rst_n = 1'b1;
    ex(S_RD, 16'h0000);
    core.rd(8'h57, 1'b1, q);
    // Lock write takes the low data byte and leaves the core running
    rs = xs(rs);
    core.cmd(8'h89);
    core.st(16'h0001, rs[15:0]);
    ex(S_LK, 16'h0001);
    ex(S_LD, 16'(rs[7:0]));
    ex(S_HALT, 16'h0000);
    ex(S_RD, 16'h0089);
    core.rd(8'h37, 1'b0, q);
    results();
  end
endmodule  // tb
`default_nettype wire
